// [rtl/arch_params.svh]
// Purpose: offsets, field positions, static values and counts for the result clamp and heat alarm
// Assumes: included by its bare name in every file that needs these constants
// Notes: types live in arch_pkg
`ifndef ARCH_PARAMS_SVH
`define ARCH_PARAMS_SVH

// reconfiguration port map
`define ARCH_ADDR_CONFIG 8'h00
`define ARCH_ADDR_MODE 8'h01
`define ARCH_ADDR_SEQ0 8'h02
`define ARCH_ADDR_SEQ1 8'h03
`define ARCH_ADDR_THRESH 8'h0E
`define ARCH_CTRL_PAGE 4'h0
`define ARCH_STATUS_PAGE 4'h1
`define ARCH_TEMP_INDEX 4'h8

// field positions
`define ARCH_MODE_SEQ_HI 15
`define ARCH_MODE_SEQ_LO 14
`define ARCH_MODE_CE 13
`define ARCH_MODE_BU 1
`define ARCH_THRESH_H_HI 15
`define ARCH_THRESH_H_LO 8
`define ARCH_THRESH_L_HI 7
`define ARCH_THRESH_L_LO 0
`define ARCH_SEQ_DEFAULT 2'h0

// static configuration, loaded at reset and on a configuration load
`define ARCH_STATIC_CONFIG 16'h0000
`define ARCH_STATIC_MODE 16'h0000
`define ARCH_STATIC_SEQ0 16'h0000
`define ARCH_STATIC_SEQ1 16'h0000
`define ARCH_STATIC_THRESH 16'hFF00

// result limits
`define ARCH_UNI_MAX 16'sh0FFF
`define ARCH_UNI_MIN 16'sh0000
`define ARCH_BI_MAX 16'sh07FF
`define ARCH_BI_MIN 16'shF800

// threshold code times sixteen lines up with the temperature code
`define ARCH_THRESH_PAD 4'h0

// alarm debounce, about 10 ms of oscillator cycles
`define ARCH_DEBOUNCE_MS 10
`define ARCH_DEBOUNCE_COUNT 20'h80000

`endif

// [rtl/arch_pkg.sv]
// Purpose: shared types of the result clamp and heat alarm
// Assumes: constants come from arch_params.svh
// Notes: used only by scoped names
package arch_pkg;

    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [15:0] wdata;
    } arch_access_t;

    typedef struct packed {
        logic enable;
        arch_access_t access;
    } arch_port_req_t;

    typedef enum logic [1:0] {
        ARCH_IDLE = 2'b00,
        ARCH_FETCH_PORT = 2'b01,
        ARCH_FETCH_DEBUG = 2'b10
    } arch_state_t;

endpackage

// [rtl/arch_result_clamp_heat_alarm.sv]
// Purpose: result clamp, status update pulse, heat alarm and reconfiguration port of the converter
// Assumes: clk is the conversion clock; port_clock and port pins come from another domain
// Notes: the debug path and the result path run on clk
// Function
// - pulse status update on the same clock edge that stores each corrected result
// - single-ended or unipolar results clamp to the range 0 to 4095
// - bipolar results clamp to the signed range -2048 to 2047
// - heat decision uses the temperature result stored at status 18h
// - raw heat flag sets when temperature exceeds the upper threshold
// - raw heat flag clears below the lower threshold, holds in between
// - alarm rises only after the raw flag stays high for the debounce count
// - a raw flag pulse shorter than the debounce keeps the alarm low
// - heat detection works only in the default scan mode
// - thresholds are scaled by sixteen against the temperature code
// - access done marks completion of a port read or write
// - the active-low reset resets the whole block except the status storage array
// - configuration load low reloads the static control values
// - debug busy is high while a debug access is in progress
// - changed flag sets on debug control write, clears on user port operation
// - in event mode each trigger pulse of at least one cycle starts exactly one conversion
`timescale 1ns/1ns
`include "arch_params.svh"
module arch_result_clamp_heat_alarm #(
    parameter logic [19:0] DEBOUNCE_CYCLES = `ARCH_DEBOUNCE_COUNT
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic static_config_load_n,
    input wire logic port_clock,
    input wire logic port_access_enable,
    input wire logic port_write_select,
    input wire logic [7:0] port_address,
    input wire logic [15:0] port_write_data,
    output logic [15:0] port_read_data,
    output logic port_access_done,
    input wire logic conversion_trigger,
    output logic conversion_start,
    input wire logic result_valid,
    input wire logic [3:0] result_channel,
    input wire logic signed [15:0] result_value,
    output logic status_update,
    output logic over_temp_alarm,
    input wire logic debug_access_req,
    input wire logic debug_write,
    input wire logic [7:0] debug_address,
    input wire logic [15:0] debug_write_data,
    output logic [15:0] debug_read_data,
    output logic debug_access_busy,
    output logic control_changed_by_debug,
    output logic [15:0] config_word,
    output logic [15:0] mode_word,
    output logic [15:0] seq0_word,
    output logic [15:0] seq1_word,
    output logic [15:0] thresh_word
);
    logic [1:0] pclk_sync;
    logic pclk_prev;
    arch_pkg::arch_port_req_t req_meta;
    arch_pkg::arch_port_req_t req_sync;
    arch_pkg::arch_port_req_t req_hold;
    arch_pkg::arch_access_t pend_req;
    logic pend;
    logic [1:0] trig_sync;
    logic trig_prev;
    logic [1:0] load_sync;
    arch_pkg::arch_access_t dbg_req;
    arch_pkg::arch_access_t ctrl_wr;
    arch_pkg::arch_state_t state;
    arch_pkg::arch_state_t next_state;
    logic pclk_rise;
    logic pclk_fall;
    logic port_take;
    logic port_serve;
    logic debug_serve;
    logic port_fetch;
    logic debug_fetch;
    logic ctrl_wr_fire;
    logic debug_ctrl_write;
    logic loading;
    logic mem_rd_en;
    logic [3:0] mem_rd_addr;
    logic [15:0] mem_rd_data;
    logic signed [15:0] clamped_result;
    logic bipolar;
    logic default_mode;
    logic temp_write;
    logic [11:0] temp_code;
    logic [11:0] upper_limit;
    logic [11:0] lower_limit;
    logic raw_over_temp;
    logic [19:0] alarm_count;

    default clocking arch_cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // every pin from the port domain passes two flops before use
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pclk_sync <= 2'h0;
            pclk_prev <= 1'b0;
            req_meta <= '0;
            req_sync <= '0;
            trig_sync <= 2'h0;
            trig_prev <= 1'b0;
            load_sync <= 2'h3;
        end else begin
            pclk_sync <= {pclk_sync[0], port_clock};
            pclk_prev <= pclk_sync[1];
            req_meta <= {port_access_enable, port_write_select, port_address, port_write_data};
            req_sync <= req_meta;
            trig_sync <= {trig_sync[0], conversion_trigger};
            trig_prev <= trig_sync[1];
            load_sync <= {load_sync[0], static_config_load_n};
        end
    end

    assign pclk_rise = pclk_sync[1] & ~pclk_prev;
    assign pclk_fall = ~pclk_sync[1] & pclk_prev;
    assign loading = ~load_sync[1];

    // the fabric changes its pins just after its rising edge, so the copy taken at
    // the falling edge is what stood at the next rising edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            req_hold <= '0;
        end else if (pclk_fall) begin
            req_hold <= req_sync;
        end
    end

    assign port_take = pclk_rise & req_hold.enable;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend <= 1'b0;
            pend_req <= '0;
        end else if (port_take) begin
            pend <= 1'b1;
            pend_req <= req_hold.access;
        end else if (port_serve) begin
            pend <= 1'b0;
        end
    end

    // port wins over debug; a debug access waits at most one fetch
    assign port_serve = (state == arch_pkg::ARCH_IDLE) && pend;
    assign debug_serve = (state == arch_pkg::ARCH_IDLE) && !pend && debug_access_busy;
    assign port_fetch = port_serve && !pend_req.write && 
                        (pend_req.addr[7:4] == `ARCH_STATUS_PAGE);
    assign debug_fetch = debug_serve && !dbg_req.write && (dbg_req.addr[7:4] == `ARCH_STATUS_PAGE);
    assign mem_rd_en = port_fetch || debug_fetch;
    assign mem_rd_addr = port_serve ? pend_req.addr[3:0] : dbg_req.addr[3:0];

    always_comb begin
        next_state = state;
        case (state)
            arch_pkg::ARCH_IDLE: begin
                if (port_fetch) begin
                    next_state = arch_pkg::ARCH_FETCH_PORT;
                end else if (debug_fetch) begin
                    next_state = arch_pkg::ARCH_FETCH_DEBUG;
                end
            end
            arch_pkg::ARCH_FETCH_PORT: next_state = arch_pkg::ARCH_IDLE;
            arch_pkg::ARCH_FETCH_DEBUG: next_state = arch_pkg::ARCH_IDLE;
            default: next_state = arch_pkg::ARCH_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= arch_pkg::ARCH_IDLE;
        end else begin
            state <= next_state;
        end
    end

    function automatic logic [15:0] ctrl_read(input logic [7:0] addr);
        case (addr)
            `ARCH_ADDR_CONFIG: ctrl_read = config_word;
            `ARCH_ADDR_MODE: ctrl_read = mode_word;
            `ARCH_ADDR_SEQ0: ctrl_read = seq0_word;
            `ARCH_ADDR_SEQ1: ctrl_read = seq1_word;
            `ARCH_ADDR_THRESH: ctrl_read = thresh_word;
            default: ctrl_read = 16'h0000;
        endcase
    endfunction

    // port read data and access done
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port_read_data <= 16'h0000;
            port_access_done <= 1'b0;
        end else if (state == arch_pkg::ARCH_FETCH_PORT) begin
            port_read_data <= mem_rd_data;
            port_access_done <= 1'b1;
        end else if (port_serve && !port_fetch) begin
            if (!pend_req.write) begin
                port_read_data <= ctrl_read(pend_req.addr);
            end
            port_access_done <= 1'b1;
        end else if (pclk_rise) begin
            port_access_done <= 1'b0;
        end
    end

    AST_DONE_AFTER_SERVE: assert property (port_serve |-> ##[1:2] port_access_done)
        else $error("access done missing after port service");

    AST_DONE_HOLDS: assert property (port_access_done && !pclk_rise && !port_serve
                                     |=> port_access_done)
        else $error("access done dropped before next port clock edge");

    AST_DONE_ENDS: assert property (port_access_done && pclk_rise && state == arch_pkg::ARCH_IDLE
                                    && !pend |=> !port_access_done)
        else $error("access done outlived one port clock cycle");

    // debug path: busy from acceptance to completion
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            debug_access_busy <= 1'b0;
            dbg_req <= '0;
        end else if (debug_access_req && !debug_access_busy) begin
            debug_access_busy <= 1'b1;
            dbg_req <= {debug_write, debug_address, debug_write_data};
        end else if ((debug_serve && !debug_fetch) || state == arch_pkg::ARCH_FETCH_DEBUG) begin
            debug_access_busy <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            debug_read_data <= 16'h0000;
        end else if (state == arch_pkg::ARCH_FETCH_DEBUG) begin
            debug_read_data <= mem_rd_data;
        end else if (debug_serve && !dbg_req.write) begin
            debug_read_data <= ctrl_read(dbg_req.addr);
        end
    end

    AST_BUSY_ON_REQ: assert property (debug_access_req && !debug_access_busy
                                      |=> debug_access_busy)
        else $error("debug busy not raised on accepted request");

    AST_BUSY_BOUNDED: assert property ($rose(debug_access_busy)
                                       |-> ##[1:4] !debug_access_busy)
        else $error("debug access did not complete in time");

    // control registers
    assign ctrl_wr_fire = (port_serve && pend_req.write) || (debug_serve && dbg_req.write);
    assign ctrl_wr = port_serve ? pend_req : dbg_req;
    assign debug_ctrl_write = debug_serve && dbg_req.write && (dbg_req.addr[7:4] == `ARCH_CTRL_PAGE);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            config_word <= `ARCH_STATIC_CONFIG;
            mode_word <= `ARCH_STATIC_MODE;
            seq0_word <= `ARCH_STATIC_SEQ0;
            seq1_word <= `ARCH_STATIC_SEQ1;
            thresh_word <= `ARCH_STATIC_THRESH;
        end else if (loading) begin
            config_word <= `ARCH_STATIC_CONFIG;
            mode_word <= `ARCH_STATIC_MODE;
            seq0_word <= `ARCH_STATIC_SEQ0;
            seq1_word <= `ARCH_STATIC_SEQ1;
            thresh_word <= `ARCH_STATIC_THRESH;
        end else if (ctrl_wr_fire) begin
            case (ctrl_wr.addr)
                `ARCH_ADDR_CONFIG: config_word <= ctrl_wr.wdata;
                `ARCH_ADDR_MODE: mode_word <= ctrl_wr.wdata;
                `ARCH_ADDR_SEQ0: seq0_word <= ctrl_wr.wdata;
                `ARCH_ADDR_SEQ1: seq1_word <= ctrl_wr.wdata;
                `ARCH_ADDR_THRESH: thresh_word <= ctrl_wr.wdata;
                default: config_word <= config_word;
            endcase
        end
    end

    AST_STATIC_LOAD: assert property (loading |=> mode_word == `ARCH_STATIC_MODE
                                      && thresh_word == `ARCH_STATIC_THRESH)
        else $error("static configuration not loaded");

    // a debug write in the same cycle as a user operation keeps the flag set
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            control_changed_by_debug <= 1'b0;
        end else if (debug_ctrl_write) begin
            control_changed_by_debug <= 1'b1;
        end else if (port_take) begin
            control_changed_by_debug <= 1'b0;
        end
    end

    AST_CHANGED_HOLDS: assert property (control_changed_by_debug && !port_take
                                        |=> control_changed_by_debug)
        else $error("changed flag cleared without a user operation");

    // event mode trigger; a pulse shorter than one cycle may be missed by the synchroniser
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conversion_start <= 1'b0;
        end else begin
            conversion_start <= mode_word[`ARCH_MODE_CE] && trig_sync[1] && !trig_prev;
        end
    end

    AST_ONE_START: assert property (conversion_start |=> !conversion_start)
        else $error("more than one conversion start for a trigger");

    // result clamp
    assign bipolar = mode_word[`ARCH_MODE_BU];

    always_comb begin
        clamped_result = result_value;
        if (bipolar) begin
            if (result_value > `ARCH_BI_MAX) begin
                clamped_result = `ARCH_BI_MAX;
            end else if (result_value < `ARCH_BI_MIN) begin
                clamped_result = `ARCH_BI_MIN;
            end
        end else begin
            if (result_value > `ARCH_UNI_MAX) begin
                clamped_result = `ARCH_UNI_MAX;
            end else if (result_value < `ARCH_UNI_MIN) begin
                clamped_result = `ARCH_UNI_MIN;
            end
        end
    end

    arch_status_mem #(
        .DATA_W(16),
        .ADDR_W(4)
    ) u_status_mem (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(result_valid),
        .wr_addr(result_channel),
        .wr_data(clamped_result),
        .rd_en(mem_rd_en),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd_data)
    );

    AST_UNI_RANGE: assert property (result_valid && !bipolar
                                    |-> clamped_result >= `ARCH_UNI_MIN
                                    && clamped_result <= `ARCH_UNI_MAX)
        else $error("unipolar result stored out of range");

    AST_BI_RANGE: assert property (result_valid && bipolar
                                   |-> clamped_result >= `ARCH_BI_MIN
                                   && clamped_result <= `ARCH_BI_MAX)
        else $error("bipolar result stored out of range");

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_update <= 1'b0;
        end else begin
            status_update <= result_valid;
        end
    end

    sequence s_one_pulse;
        status_update ##1 !status_update;
    endsequence

    AST_UPDATE_PULSE: assert property (result_valid ##1 !result_valid |-> s_one_pulse)
        else $error("status update is not a single cycle pulse");

    // heat detection from the stored temperature result
    assign default_mode = mode_word[`ARCH_MODE_SEQ_HI:`ARCH_MODE_SEQ_LO] == `ARCH_SEQ_DEFAULT;
    assign temp_write = result_valid && (result_channel == `ARCH_TEMP_INDEX);
    assign temp_code = clamped_result[11:0];
    assign upper_limit = {thresh_word[`ARCH_THRESH_H_HI:`ARCH_THRESH_H_LO], `ARCH_THRESH_PAD};
    assign lower_limit = {thresh_word[`ARCH_THRESH_L_HI:`ARCH_THRESH_L_LO], `ARCH_THRESH_PAD};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            raw_over_temp <= 1'b0;
        end else if (!default_mode) begin
            raw_over_temp <= 1'b0;
        end else if (temp_write) begin
            if (temp_code > upper_limit) begin
                raw_over_temp <= 1'b1;
            end else if (temp_code < lower_limit) begin
                raw_over_temp <= 1'b0;
            end
        end
    end

    AST_RAW_SET: assert property (default_mode && temp_write && temp_code > upper_limit
                                  |=> raw_over_temp)
        else $error("raw heat flag not set above upper threshold");

    AST_RAW_CLEAR: assert property (temp_write && temp_code < lower_limit
                                    && !(temp_code > upper_limit) |=> !raw_over_temp)
        else $error("raw heat flag not cleared below lower threshold");

    AST_RAW_HOLD: assert property (default_mode && temp_write && temp_code >= lower_limit
                                   && temp_code <= upper_limit |=> $stable(raw_over_temp))
        else $error("raw heat flag changed between thresholds");

    // debounce: the counter restarts whenever the raw flag drops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_count <= 20'h00000;
        end else if (!raw_over_temp) begin
            alarm_count <= 20'h00000;
        end else if (alarm_count != DEBOUNCE_CYCLES) begin
            alarm_count <= alarm_count + 20'h00001;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            over_temp_alarm <= 1'b0;
        end else begin
            over_temp_alarm <= raw_over_temp && (alarm_count == DEBOUNCE_CYCLES);
        end
    end

    AST_ALARM_COUNTED: assert property ($rose(over_temp_alarm)
                                        |-> $past(alarm_count) == DEBOUNCE_CYCLES
                                        && $past(raw_over_temp))
        else $error("alarm rose before the debounce count");

    AST_ALARM_DROPS: assert property (!raw_over_temp |=> !over_temp_alarm)
        else $error("alarm high without raw heat flag");

    AST_ALARM_MODE: assert property (!default_mode |-> ##2 !over_temp_alarm)
        else $error("alarm outside default scan mode");

endmodule

// [rtl/arch_status_mem.sv]
// Purpose: status register storage with one write port and one registered read port
// Assumes: single clock, reads and writes may share a cycle
// Notes: contents are undefined until written; a read of the address being written returns old data
`timescale 1ns/1ns
module arch_status_mem #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];

    // no reset on the array so it maps onto plain memory
    always_ff @(posedge clk) begin
        if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= store[rd_addr];
        end
    end
endmodule

// [sim/arch_fabric_model.sv]
// Purpose: fabric side of the reconfiguration port
// Assumes: port clock halts low between transfers
// Notes: released lines show the inverse of their last value
`timescale 1ns/1ns
module arch_fabric_model (
    output logic port_clock,
    output logic port_access_enable,
    output logic port_write_select,
    output logic [7:0] port_address,
    output logic [15:0] port_write_data,
    input wire logic [15:0] port_read_data,
    input wire logic port_access_done
);
    logic run = 1'b0;
    initial begin
        {port_clock, port_access_enable, port_write_select, port_address} = 11'h000;
        port_write_data = 16'h0000;
        // odd offset keeps port edges clear of clk edges
        #7;
        forever #40 if (run || port_clock) port_clock <= ~port_clock;
    end
    task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                          output logic [15:0] q, output logic ok);
        run = 1'b1;
        @(posedge port_clock);
        port_access_enable <= 1'b1;
        port_write_select <= wr;
        port_address <= a;
        port_write_data <= d;
        // enable is a one-period strobe: holding it over a second rise would issue a second access
        @(posedge port_clock);
        port_access_enable <= 1'b0;
        {port_write_select, port_address, port_write_data} <= ~{wr, a, d};
        @(posedge port_clock);
        q = port_read_data;
        ok = port_access_done;
        run = 1'b0;
    endtask
endmodule

// [sim/arch_result_clamp_heat_alarm_bench.sv]
// Purpose: self-checking bench of the result clamp and heat alarm
// Assumes: debounce shortened to sixteen cycles
// Notes: the fabric model runs the reconfiguration port
`timescale 1ns/1ns
module arch_result_clamp_heat_alarm_bench;
    logic clk = 1'b0, reset_n = 1'b0, static_config_load_n = 1'b1, conversion_trigger = 1'b0;
    logic result_valid = 1'b0, debug_access_req = 1'b0, debug_write = 1'b0;
    logic [3:0] result_channel = 4'h0;
    logic signed [15:0] result_value = 16'sh0000;
    logic [7:0] debug_address = 8'h00, port_address;
    logic [15:0] debug_write_data = 16'h0000, port_read_data, port_write_data, q;
    logic port_clock, port_access_enable, port_write_select, port_access_done, ok;
    logic conversion_start, status_update, over_temp_alarm, debug_access_busy;
    logic control_changed_by_debug;
    logic [15:0] config_word, thresh_word, mode_word, seq0_word, seq1_word, debug_read_data;
    int errors = 0, checks_done = 0;
    always #5 clk = ~clk;
    arch_fabric_model fab (.port_clock, .port_access_enable, .port_write_select,
        .port_address, .port_write_data, .port_read_data, .port_access_done);
    arch_result_clamp_heat_alarm #(.DEBOUNCE_CYCLES(20'h00010)) dut (.clk, .reset_n,
        .static_config_load_n, .port_clock, .port_access_enable, .port_write_select,
        .port_address, .port_write_data, .port_read_data, .port_access_done,
        .conversion_trigger, .conversion_start, .result_valid, .result_channel,
        .result_value, .status_update, .over_temp_alarm, .debug_access_req, .debug_write,
        .debug_address, .debug_write_data, .debug_read_data, .debug_access_busy,
        .control_changed_by_debug, .config_word, .mode_word, .seq0_word,
        .seq1_word, .thresh_word);
    task automatic ck(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic cb(input logic s, input logic e);
        ck({15'h0, s}, {15'h0, e});
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pw(input logic [7:0] a, input logic [15:0] d);
        fab.access(1'b1, a, d, q, ok);
        cb(ok, 1'b1);
    endtask
    task automatic pr(input logic [7:0] a, input logic [15:0] e);
        fab.access(1'b0, a, 16'h0000, q, ok);
        cb(ok, 1'b1);
        ck(q, e);
    endtask
    task automatic res(input logic [3:0] ch, input logic [15:0] v);
        @(posedge clk);
        result_valid <= 1'b1;
        result_channel <= ch;
        result_value <= v;
        @(posedge clk);
        result_valid <= 1'b0;
        #1 cb(status_update, 1'b1);
        wt(1);
        cb(status_update, 1'b0);
    endtask
    task automatic cl(input logic [3:0] ch, input logic [15:0] v, input logic [15:0] e);
        res(ch, v);
        pr({4'h1, ch}, e);
    endtask
    // one debug access; busy must be gone within four cycles when the port is quiet
    task automatic dbg(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        debug_access_req <= 1'b1;
        debug_write <= w;
        debug_address <= a;
        debug_write_data <= d;
        @(posedge clk);
        debug_access_req <= 1'b0;
        #1 cb(debug_access_busy, 1'b1);
        wt(4);
        cb(debug_access_busy, 1'b0);
    endtask
    // counts start pulses for one trigger held two cycles
    task automatic trg(input logic [15:0] e);
        logic [15:0] n;
        n = 16'h0000;
        @(posedge clk);
        conversion_trigger <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            conversion_trigger <= (i < 1);
            #1 n = n + {15'h0, conversion_start};
        end
        ck(n, e);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // a hang anywhere counts as a mismatch
    initial begin
        repeat (50000) @(posedge clk);
        errors++;
        complete_run;
    end
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        wt(5);
        ck(config_word, 16'h0000);
        ck(thresh_word, 16'hFF00);
        ck(seq0_word, 16'h0000);
        ck(seq1_word, 16'h0000);
        cl(4'h0, 16'h1388, 16'h0FFF);
        cl(4'h1, 16'hFFFB, 16'h0000);
        cl(4'h2, 16'h0064, 16'h0064);
        pw(8'h01, 16'h0002);
        cl(4'h3, 16'h0BB8, 16'h07FF);
        cl(4'h4, 16'hF448, 16'hF800);
        cl(4'h5, 16'hFFFB, 16'hFFFB);
        pw(8'h01, 16'h0000);
        pw(8'h0E, 16'h1008);
        res(4'h8, 16'h0100);
        wt(20);
        cb(over_temp_alarm, 1'b0);
        res(4'h8, 16'h0101);
        wt(12);
        cb(over_temp_alarm, 1'b0);
        wt(8);
        cb(over_temp_alarm, 1'b1);
        pr(8'h18, 16'h0101);
        res(4'h8, 16'h0090);
        wt(3);
        cb(over_temp_alarm, 1'b1);
        res(4'h8, 16'h007F);
        wt(3);
        cb(over_temp_alarm, 1'b0);
        res(4'h8, 16'h0200);
        wt(5);
        res(4'h8, 16'h007F);
        wt(20);
        cb(over_temp_alarm, 1'b0);
        pw(8'h01, 16'h4000);
        res(4'h8, 16'h0200);
        wt(20);
        cb(over_temp_alarm, 1'b0);
        pw(8'h01, 16'h2000);
        ck(mode_word, 16'h2000);
        trg(16'h0001);
        pw(8'h01, 16'h0000);
        trg(16'h0000);
        dbg(1'b1, 8'h00, 16'h1234);
        cb(control_changed_by_debug, 1'b1);
        dbg(1'b0, 8'h10, 16'h0000);
        ck(debug_read_data, 16'h0FFF);
        cb(control_changed_by_debug, 1'b1);
        pr(8'h00, 16'h1234);
        cb(control_changed_by_debug, 1'b0);
        @(posedge clk);
        static_config_load_n <= 1'b0;
        wt(5);
        ck(config_word, 16'h0000);
        ck(thresh_word, 16'hFF00);
        complete_run;
    end
endmodule
